//--- logic/bscrg_top.sv
`timescale 1ns/1ps
// Function
// (R1) Logic held in reset until 5 V rises
// (R2) 5 V falling threshold forces hard reset
// (R3) Core reset released only when all rails good
// (R4) Sample strap, pick lowest index under ceiling
// (R5) Index selects addresses, logic level, boot mode
// (R6) Open resistor decodes as index zero
// (R7) Addresses presented as 7-bit values
// (R8) Index eight boots firmware update mode
// (R9) Power cycle or enable dip reboots
// (R10) Endpoint on port A only when enabled
// (R11) Settings latched once per boot
module bscrg_top (
    input  wire logic              mclk,                 // 40 MHz clock
    input  wire logic              rst,                  // Sync reset, high
    input  wire logic              five_volt_rail_ok,    // 5 V above rising threshold
    input  wire logic              five_volt_rail_fail,  // 5 V below falling threshold
    input  wire logic              three_v3_rail_ok,     // 3.3 V above rising threshold
    input  wire logic              one_v5_rail_ok,       // 1.5 V above rising threshold
    input  wire logic              enable_undervoltage_input, // Enable above operating level
    input  wire logic              adc_valid,            // Strap conversion done, pulse
    input  wire logic [7:0]        adc_value,            // Strap conversion result
    input  wire logic              endpoint_enable,      // Firmware request for endpoint
    output logic                   adc_start,            // Request strap conversion, pulse
    output logic                   logic_reset,          // Block logic held in reset
    output logic                   embedded_core_reset,  // Core reset, high holds
    output bscrg_pkg::bscrg_cfg_t  cfg,                  // Latched strap settings
    output logic                   cfg_valid,            // Settings latched this boot
    output logic                   endpoint_connect      // Endpoint on port A data pins
);
    import bscrg_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync_a;       // First stage, read only by sync_b
    logic [4:0] sync_b;       // Second stage, safe to use
    logic       s_5v_ok;      // Synchronised 5 V good
    logic       s_5v_fail;    // Synchronised 5 V fail
    logic       s_3v3_ok;     // Synchronised 3.3 V good
    logic       s_1v5_ok;     // Synchronised 1.5 V good
    logic       s_enable;     // Synchronised enable level

    // Comparators run off the supply, not mclk, so two flops each
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end
        else
        begin
            sync_a <= {enable_undervoltage_input, one_v5_rail_ok, three_v3_rail_ok,
                       five_volt_rail_fail, five_volt_rail_ok};
            sync_b <= sync_a;
        end
    end

    assign s_5v_ok   = sync_b[0];
    assign s_5v_fail = sync_b[1];
    assign s_3v3_ok  = sync_b[2];
    assign s_1v5_ok  = sync_b[3];
    assign s_enable  = sync_b[4];

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Lowest index whose ceiling is not exceeded
    function automatic logic [3:0] strap_index(input logic [7:0] v);
        logic [3:0] idx;
        idx = STRAP_INDEX_UPDATE;
        for (int i = STRAP_INDEX_COUNT - 1; i >= 0; i--)
        begin
            if (v <= STRAP_CEILING[i])
                idx = 4'(i);
        end
        return idx;  // see (R4) (R6)
    endfunction : strap_index

    // Settings from an index
    function automatic bscrg_cfg_t strap_cfg(input logic [3:0] idx);
        bscrg_cfg_t c;
        c.index     = idx;
        c.addr_a    = LOW_ADDR_MASK[idx] ? ADDR_A_LOW : ADDR_A_HIGH;  // see (R5) (R7)
        c.addr_b    = LOW_ADDR_MASK[idx] ? ADDR_B_LOW : ADDR_B_HIGH;  // see (R5) (R7)
        c.logic_1v8 = LOGIC_18_MASK[idx];                               // see (R5)
        if (idx == STRAP_INDEX_UPDATE)
            c.boot_mode = BSCRG_BOOT_FW_UPD;                            // see (R8)
        else if (EXT_HOST_MASK[idx])
            c.boot_mode = BSCRG_BOOT_EXT_HOST;                          // see (R5)
        else
            c.boot_mode = BSCRG_BOOT_EEPROM;                            // see (R5)
        return c;
    endfunction : strap_cfg

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    bscrg_state_t state;       // Current state
    logic         all_good;    // All rails up and enabled
    logic         boot_drop;   // Any condition that restarts boot

    // Enable dip or 5 V loss restarts boot and re-reads the strap
    assign all_good  = s_5v_ok && s_3v3_ok && s_1v5_ok && s_enable;
    assign boot_drop = s_5v_fail || !s_5v_ok || !s_enable;  // see (R1) (R2) (R9)

    // Strap is sampled only after 5 V is up so its bias is valid
    always_ff @(posedge mclk)
    begin
        if (rst)
            state <= BSCRG_ST_OFF;
        else if (boot_drop)
            state <= BSCRG_ST_OFF;                           // see (R2)
        else
        begin
            case (state)
                BSCRG_ST_OFF:    state <= BSCRG_ST_SAMPLE;   // see (R1)
                BSCRG_ST_SAMPLE: state <= BSCRG_ST_WAIT;
                BSCRG_ST_WAIT:   if (adc_valid) state <= BSCRG_ST_RUN;
                default:         state <= BSCRG_ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Conversion request
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            adc_start <= 1'b0;
        else
            adc_start <= (state == BSCRG_ST_SAMPLE) && !boot_drop;  // see (R4)
    end

    // ------------------------------------------------------------
    // Settings latch
    // ------------------------------------------------------------
    // Captured once per boot; a stray conversion later cannot move it
    always_ff @(posedge mclk)
    begin
        if (rst || boot_drop)
        begin
            cfg       <= CFG_RESET;                          // see (R6)
            cfg_valid <= 1'b0;
        end
        else if (state == BSCRG_ST_WAIT && adc_valid)
        begin
            cfg       <= strap_cfg(strap_index(adc_value));  // see (R4) (R11)
            cfg_valid <= 1'b1;                               // see (R11)
        end
    end

    // ------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            logic_reset <= 1'b1;
        else
            logic_reset <= boot_drop;                        // see (R1) (R2)
    end

    // Core waits for all three rails and a latched strap
    always_ff @(posedge mclk)
    begin
        if (rst)
            embedded_core_reset <= 1'b1;
        else
            embedded_core_reset <= !(all_good && state == BSCRG_ST_RUN
                                     && !s_5v_fail);         // see (R3)
    end

    // ------------------------------------------------------------
    // Endpoint connection
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            endpoint_connect <= 1'b0;
        else
            endpoint_connect <= endpoint_enable && !embedded_core_reset;  // see (R10)
    end

endmodule : bscrg_top

//--- logic/bscrg_pkg.sv
package bscrg_pkg;

    // ------------------------------------------------------------
    // Strap decode ceilings, one per index
    // ------------------------------------------------------------
    localparam int         STRAP_INDEX_COUNT = 9;
    localparam logic [7:0] STRAP_CEILING [STRAP_INDEX_COUNT] = '{
        8'h0a, 8'h18, 8'h2a, 8'h3f, 8'h59, 8'h77, 8'h9c, 8'hc9, 8'hff
    };
    localparam logic [3:0] STRAP_INDEX_UPDATE = 4'h8;  // Firmware update index
    localparam logic [3:0] STRAP_INDEX_RESET  = 4'h0;  // Open resistor default

    // ------------------------------------------------------------
    // Target addresses, 7 bits each
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_A_LOW  = 7'h22;
    localparam logic [6:0] ADDR_B_LOW  = 7'h26;
    localparam logic [6:0] ADDR_A_HIGH = 7'h23;
    localparam logic [6:0] ADDR_B_HIGH = 7'h27;

    // Index membership masks, bit n set for index n
    localparam logic [8:0] LOW_ADDR_MASK  = 9'h1a5;  // 0,2,5,7,8
    localparam logic [8:0] LOGIC_18_MASK  = 9'h0cc;  // 2,3,6,7
    localparam logic [8:0] EXT_HOST_MASK  = 9'h0aa;  // 1,3,5,7

    // ------------------------------------------------------------
    // Boot modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BSCRG_BOOT_EEPROM   = 2'b00,
        BSCRG_BOOT_EXT_HOST = 2'b01,
        BSCRG_BOOT_FW_UPD   = 2'b10
    } bscrg_boot_t;

    // Settings derived from the strap
    typedef struct packed {
        logic [3:0]  index;        // Decoded strap index
        logic [6:0]  addr_a;       // Port A target address
        logic [6:0]  addr_b;       // Port B target address
        logic        logic_1v8;    // 1 = 1.8 V bus logic, 0 = 3.3 V
        bscrg_boot_t boot_mode;    // Boot source
    } bscrg_cfg_t;

    // Reset value of the settings: index 0
    localparam bscrg_cfg_t CFG_RESET = '{
        index: 4'h0, addr_a: 7'h22, addr_b: 7'h26, logic_1v8: 1'b0,
        boot_mode: BSCRG_BOOT_EEPROM
    };

    // Sequencer states
    typedef enum logic [1:0] {
        BSCRG_ST_OFF    = 2'b00,
        BSCRG_ST_SAMPLE = 2'b01,
        BSCRG_ST_WAIT   = 2'b10,
        BSCRG_ST_RUN    = 2'b11
    } bscrg_state_t;

endpackage : bscrg_pkg

//--- dv/bscrg_strap_model.sv
`timescale 1ns/1ps
// ------------------------------
// Strap resistor seen through ADC
// ------------------------------
module bscrg_strap_model (
    input  wire logic       mclk,
    input  wire logic       start,
    input  wire logic [7:0] level,
    output logic            valid = 1'b0,
    output logic [7:0]      value = 8'h5a
);
    logic [3:0] cnt = 4'h0;  // Answer lag varies with the reading
    // Idle bus toggles, so stale data never passes as a result
    always_ff @(posedge mclk)
    begin
        valid <= 1'b0;
        value <= ~value;
        if (start)
            cnt <= {1'b0, level[2:0]} + 4'h1;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
        if (cnt == 4'h1)
        begin
            valid <= 1'b1;
            value <= level;
        end
    end
endmodule : bscrg_strap_model

//--- dv/bscrg_top_monitor.sv
`timescale 1ns/1ps
// ------------------------------
// Boot sequencing checks
// ------------------------------
module bscrg_top_monitor
    import bscrg_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  five_volt_rail_ok,
    input wire logic                  five_volt_rail_fail,
    input wire logic                  three_v3_rail_ok,
    input wire logic                  one_v5_rail_ok,
    input wire logic [7:0]            adc_value,
    input wire logic                  endpoint_enable,
    input wire logic                  adc_start,
    input wire logic                  logic_reset,
    input wire logic                  embedded_core_reset,
    input wire bscrg_pkg::bscrg_cfg_t cfg,
    input wire logic                  cfg_valid,
    input wire logic                  endpoint_connect
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Lowest index whose ceiling holds the reading
    function automatic logic [3:0] dec(input logic [7:0] v);
        dec = 4'h8;
        for (int i = 7; i >= 0; i--)
            if (v <= STRAP_CEILING[i])
                dec = 4'(i);
    endfunction : dec
    property p_rise; !five_volt_rail_ok [*5] |-> logic_reset; endproperty
    a_rise: assert property (p_rise) else $error("ran without 5 V");
    property p_fall;
        five_volt_rail_fail [*8] |-> logic_reset && embedded_core_reset && !cfg_valid;
    endproperty
    a_fall: assert property (p_fall) else $error("no hard reset");
    property p_rails;
        (!three_v3_rail_ok || !one_v5_rail_ok) [*5] |-> embedded_core_reset;
    endproperty
    a_rails: assert property (p_rails) else $error("core ran early");
    property p_core; !embedded_core_reset |-> $past(cfg_valid); endproperty
    a_core: assert property (p_core) else $error("core ran unconfigured");
    property p_start; adc_start |-> !logic_reset ##1 !adc_start; endproperty
    a_start: assert property (p_start) else $error("bad sample request");
    property p_dec; $rose(cfg_valid) |-> cfg.index == dec($past(adc_value)); endproperty
    a_dec: assert property (p_dec) else $error("wrong strap index");
    property p_hold; $past(cfg_valid) && cfg_valid |-> $stable(cfg); endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_ep;
        endpoint_connect == ($past(endpoint_enable) && !$past(embedded_core_reset));
    endproperty
    a_ep: assert property (p_ep) else $error("endpoint wrong");
endmodule : bscrg_top_monitor

bind bscrg_top bscrg_top_monitor u_mon (.mclk, .rst, .five_volt_rail_ok, .five_volt_rail_fail,
    .three_v3_rail_ok, .one_v5_rail_ok, .adc_value, .endpoint_enable, .adc_start,
    .logic_reset, .embedded_core_reset, .cfg, .cfg_valid, .endpoint_connect);

//--- dv/testbench.sv
`timescale 1ns/1ps
// ------------------------------
// Boot and strap bench
// ------------------------------
module testbench;
    import bscrg_pkg::*;
    logic       mclk = 1'b0, rst = 1'b1, ok5 = 1'b0, fail5 = 1'b0, ok33 = 1'b1, ok15 = 1'b1;
    logic       en = 1'b1, ep_en = 1'b0, start, lrst, crst, cvalid, ep_con, avalid;
    logic [7:0] level = 8'h00, aval;
    bscrg_cfg_t cfg;
    int         mismatches = 0, total_checks = 0, i;
    logic [7:0] ceil_t [9] = '{8'h0a, 8'h18, 8'h2a, 8'h3f, 8'h59, 8'h77, 8'h9c, 8'hc9, 8'hff};
    initial
        forever #12.5 mclk = ~mclk;
    bscrg_top DUT (.mclk(mclk), .rst(rst), .five_volt_rail_ok(ok5), .five_volt_rail_fail(fail5),
        .three_v3_rail_ok(ok33), .one_v5_rail_ok(ok15), .enable_undervoltage_input(en),
        .adc_valid(avalid), .adc_value(aval), .endpoint_enable(ep_en), .adc_start(start),
        .logic_reset(lrst), .embedded_core_reset(crst), .cfg(cfg), .cfg_valid(cvalid),
        .endpoint_connect(ep_con));
    bscrg_strap_model u_strap (.mclk(mclk), .start(start), .level(level), .valid(avalid),
        .value(aval));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic chk_b(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_b
    task automatic chk_c(input bscrg_cfg_t got, input bscrg_cfg_t exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_c
    // Settings expected for one strap index
    function automatic bscrg_cfg_t exp_cfg(input logic [3:0] x);
        bscrg_cfg_t c;
        c.index     = x;
        c.addr_a    = (x == 0 || x == 2 || x == 5 || x >= 7) ? 7'h22 : 7'h23;
        c.addr_b    = c.addr_a + 7'h04;
        c.logic_1v8 = x == 2 || x == 3 || x == 6 || x == 7;
        if (x == 8)
            c.boot_mode = BSCRG_BOOT_FW_UPD;
        else if (x[0])
            c.boot_mode = BSCRG_BOOT_EXT_HOST;
        else
            c.boot_mode = BSCRG_BOOT_EEPROM;
        return c;
    endfunction : exp_cfg
    // Bounded wait for settings latched, or for core release
    task automatic wait_on(input logic core);
        int n;
        for (n = 0; n < 60 && (core ? crst !== 1'b0 : cvalid !== 1'b1); n++)
            @(negedge mclk);
        if (n == 60)
        begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            complete_run();
        end
    endtask : wait_on
    // Enable dip forces a fresh boot with a new strap reading
    task automatic boot(input logic [7:0] v, input logic [3:0] x, input logic rel);
        en    = 1'b0;
        level = v;
        repeat (5) @(negedge mclk);
        chk_b(cvalid, 1'b0);
        en = 1'b1;
        wait_on(1'b0);
        chk_b(lrst, 1'b0);
        chk_c(cfg, exp_cfg(x));
        if (rel)
            wait_on(1'b1);
    endtask : boot
    initial
    begin
        repeat (8) @(negedge mclk);
        chk_b(lrst, 1'b1);
        chk_c(cfg, exp_cfg(4'h0));
        rst = 1'b0;
        repeat (10) @(negedge mclk);
        chk_b(lrst, 1'b1);
        ok5 = 1'b1;
        boot(8'h00, 4'h0, 1'b1);
        for (i = 0; i < 17; i++)
            boot(i < 9 ? ceil_t[i] : ceil_t[i - 9] + 8'h01, 4'(i < 9 ? i : i - 8), 1'b1);
        $display("test strap done");
        ok15 = 1'b0;
        boot(8'h3f, 4'h3, 1'b0);
        ep_en = 1'b1;
        repeat (10) @(negedge mclk);
        chk_b(crst, 1'b1);
        chk_b(ep_con, 1'b0);
        ok15 = 1'b1;
        wait_on(1'b1);
        repeat (2) @(negedge mclk);
        chk_b(ep_con, 1'b1);
        ok33 = 1'b0;
        repeat (5) @(negedge mclk);
        chk_b(crst, 1'b1);
        chk_b(ep_con, 1'b0);
        ok33 = 1'b1;
        wait_on(1'b1);
        $display("test rails done");
        fail5 = 1'b1;
        repeat (8) @(negedge mclk);
        chk_b(crst, 1'b1);
        chk_b(ep_con, 1'b0);
        chk_c(cfg, exp_cfg(4'h0));
        fail5 = 1'b0;
        wait_on(1'b0);
        chk_c(cfg, exp_cfg(4'h3));
        ok5 = 1'b0;
        repeat (5) @(negedge mclk);
        chk_b(lrst, 1'b1);
        chk_b(cvalid, 1'b0);
        ok5 = 1'b1;
        wait_on(1'b1);
        chk_c(cfg, exp_cfg(4'h3));
        $display("test drop done");
        complete_run();
    end
endmodule : testbench
